// ---- rtl/adc_ctl_pkg.sv ----
// constants, register map and carrier types of the converter control block
package adc_ctl_pkg;

	localparam int unsigned ADDR_W   = 5;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned SEQ_LEN  = 4;
	localparam int unsigned IDX_W    = 2;
	localparam int unsigned CH_N     = 8;
	localparam int unsigned IRQ_W    = 3;

	////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_TRIG_SEL  = 5'h01;
	localparam logic [ADDR_W-1:0] OFF_CTL2      = 5'h02;
	localparam logic [ADDR_W-1:0] OFF_PRESCALE  = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_START     = 5'h05;
	localparam logic [ADDR_W-1:0] OFF_THRESH    = 5'h06;
	localparam logic [ADDR_W-1:0] OFF_DONE_FLG  = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_CMP_EN    = 5'h09;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 5'h0a;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 5'h0b;
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_RESULT    = 5'h10;
	localparam logic [ADDR_W-1:0] RESULT_MASK   = 5'h1c;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned CTL2_FAST_CLEAR  = 6;
	localparam int unsigned CTL2_STOP_CLK    = 5;
	localparam int unsigned CTL2_TRIG_LEVEL  = 4;
	localparam int unsigned CTL2_TRIG_POL    = 3;
	localparam int unsigned CTL2_TRIG_EN     = 2;
	localparam int unsigned TSEL_SOURCE      = 7;
	localparam int unsigned IRQ_SEQ_DONE     = 0;
	localparam int unsigned IRQ_CMP_HIT      = 1;
	localparam int unsigned IRQ_ABORTED      = 2;

	////////////////////////////////////////////////////////////////////////////
	// reset values and timing
	localparam logic [7:0] CTL2_RST      = 8'h00;
	localparam logic [7:0] TSEL_RST      = 8'h00;
	localparam logic [4:0] PRESCALE_RST  = 5'h05;
	localparam logic [7:0] THRESH_RST    = 8'h80;
	localparam logic [4:0] INT_CLK_DIV   = 5'h06;
	localparam logic [3:0] CONV_TICKS    = 4'ha;
	localparam logic [2:0] LAST_AN       = 3'h7;
	localparam logic       DEDICATED_TRIG_PRESENT = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_t;

	typedef struct packed {
		logic              stop_req;
		logic [3:0]        dedicated_trigger_inputs;
		logic [CH_N-1:0]   an_level;
	} pins_t;

	typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} seq_state_t;

endpackage

// ---- rtl/ext_trigger_detect.sv ----
// external trigger sensitivity detector: edge or level, either polarity
module ext_trigger_detect (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic trig_in,
	input  wire logic level_mode,
	input  wire logic polarity,
	input  wire logic armed,
	output logic      fire
);

	logic prev_q;
	logic active;
	logic hit;

	// active level is the polarity bit itself: 0 low/falling, 1 high/rising
	assign active = (trig_in == polarity); // RQ14
	// level mode fires while active, edge mode only on the change into it
	assign hit = level_mode ? active : (active && (prev_q != polarity)); // RQ13 RQ16

	// history kept even while disarmed so enabling never fakes an edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
			fire   <= 1'b0;
		end else begin
			prev_q <= trig_in;
			fire   <= armed & hit;
		end
	end

endmodule // ext_trigger_detect

// ---- rtl/adc_control.sv ----
// converter control two: flag clearing, stop mode clocking, external trigger
// Operation
// RQ1: any control write aborts running sequence
// RQ2: register at offset two, always accessible
// RQ3: normal mode: flag cleared by writing one
// RQ4: fast clear, no compare: result read clears
// RQ5: fast clear, compare: result write clears
// RQ6: stop with bit set: internal clock, continue
// RQ7: prescaler never alters internal clock rate
// RQ8: external trigger ignored during stop mode
// RQ9: mode-spanning conversion stores and flags nothing
// RQ10: stop with bit clear: abort, restart after
// RQ11: interrupts still signal during stop conversions
// RQ12: software waits recovery time after stop exit
// RQ13: bit four selects level or edge trigger
// RQ14: bit three selects trigger polarity
// RQ15: no dedicated inputs: source bit ignored
// RQ16: 00 fall, 01 rise, 10 low, 11 high
// RQ17: bit two enables trigger, channel buffer on
//
// The address-and-strobe port was chosen for this implementation.
module adc_control (
	input  wire logic                              clk_sys,
	input  wire logic                              rstn,
	input  wire adc_ctl_pkg::reg_req_t             bus_req,
	output logic [adc_ctl_pkg::DATA_W-1:0]         rdata,
	input  wire adc_ctl_pkg::pins_t                pins,
	input  wire logic [adc_ctl_pkg::DATA_W-1:0]    analog_code,
	output logic                                   irq,
	output logic [adc_ctl_pkg::CH_N-1:0]           digital_input_enable,
	output logic                                   internal_clock_active,
	output logic                                   busy
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	adc_ctl_pkg::pins_t                       pins_s1_q, pins_s2_q;
	logic [adc_ctl_pkg::DATA_W-1:0]           code_s1_q, code_s2_q;
	logic [7:0]                               converter_control_two_q;
	logic [7:0]                               trig_sel_q;
	logic [4:0]                               prescale_q;
	logic [7:0]                               thresh_q;
	logic [adc_ctl_pkg::SEQ_LEN-1:0]          conversion_complete_flag_q;
	logic [adc_ctl_pkg::SEQ_LEN-1:0]          compare_enable_q;
	logic [7:0]                               result_q [adc_ctl_pkg::SEQ_LEN];
	logic [adc_ctl_pkg::IRQ_W-1:0]            irq_stat_q, irq_mask_q;
	adc_ctl_pkg::seq_state_t                  state_q;
	logic [adc_ctl_pkg::IDX_W-1:0]            idx_q;
	logic [3:0]                               tick_cnt_q;
	logic [5:0]                               div_cnt_q;
	logic                                     tick_q;
	logic                                     stop_prev_q;
	logic                                     tainted_q;
	logic                                     restart_pending_q;
	logic                                     stop_s, stop_enter, stop_exit;
	logic                                     stop_int_clk, held_in_stop;
	logic                                     wr_ctl, abort, sw_start, trig_fire, start;
	logic                                     conv_done, store_ok, cmp_hit, seq_done;
	logic                                     trig_raw, trig_armed, fast_clear;
	logic [2:0]                               an_sel;
	logic [5:0]                               div_limit;
	logic [adc_ctl_pkg::SEQ_LEN-1:0]          done_flag_set, done_flag_clr;
	logic [adc_ctl_pkg::IRQ_W-1:0]            irq_set;
	logic [adc_ctl_pkg::IDX_W-1:0]            acc_idx;

	// result registers decode at several places, so one function
	function automatic logic is_result(input logic [adc_ctl_pkg::ADDR_W-1:0] a);
		is_result = (a & adc_ctl_pkg::RESULT_MASK) == adc_ctl_pkg::OFF_RESULT;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers; first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			code_s1_q <= 8'h00;
			code_s2_q <= 8'h00;
		end else begin
			pins_s1_q <= pins;
			pins_s2_q <= pins_s1_q;
			code_s1_q <= analog_code;
			code_s2_q <= code_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decode of events
	assign stop_s       = pins_s2_q.stop_req;
	assign stop_enter   = stop_s & ~stop_prev_q;
	assign stop_exit    = ~stop_s & stop_prev_q;
	assign stop_int_clk = converter_control_two_q[adc_ctl_pkg::CTL2_STOP_CLK];
	assign held_in_stop = stop_s & ~stop_int_clk;
	assign fast_clear   = converter_control_two_q[adc_ctl_pkg::CTL2_FAST_CLEAR];
	// writes to either control register kill the sequence
	assign wr_ctl = bus_req.wr && (bus_req.addr == adc_ctl_pkg::OFF_CTL2
		|| bus_req.addr == adc_ctl_pkg::OFF_TRIG_SEL); // RQ1
	assign abort    = wr_ctl | (stop_enter & ~stop_int_clk & (state_q == adc_ctl_pkg::ST_CONVERT)); // RQ1 RQ10
	assign sw_start = bus_req.wr && (bus_req.addr == adc_ctl_pkg::OFF_START);
	assign start    = ~abort & ~held_in_stop & (sw_start | trig_fire
		| (stop_exit & restart_pending_q)); // RQ10
	assign acc_idx  = bus_req.addr[adc_ctl_pkg::IDX_W-1:0];

	////////////////////////////////////////////////////////////////////////////
	// external trigger source and arming
	// channel codes above the last input all map to the last input
	assign an_sel = trig_sel_q[3] ? adc_ctl_pkg::LAST_AN : trig_sel_q[2:0];
	always_comb begin
		// without dedicated inputs the source bit has no effect
		if (adc_ctl_pkg::DEDICATED_TRIG_PRESENT && trig_sel_q[adc_ctl_pkg::TSEL_SOURCE]) begin // RQ15
			trig_raw = pins_s2_q.dedicated_trigger_inputs[trig_sel_q[1:0]];
		end else begin
			trig_raw = pins_s2_q.an_level[an_sel]; // RQ15
		end
	end
	// trigger only starts an idle sequencer, and never during stop
	assign trig_armed = converter_control_two_q[adc_ctl_pkg::CTL2_TRIG_EN] & ~stop_s
		& (state_q == adc_ctl_pkg::ST_IDLE); // RQ8 RQ17

	ext_trigger_detect u_trig (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.trig_in    (trig_raw),
		.level_mode (converter_control_two_q[adc_ctl_pkg::CTL2_TRIG_LEVEL]),
		.polarity   (converter_control_two_q[adc_ctl_pkg::CTL2_TRIG_POL]),
		.armed      (trig_armed),
		.fire       (trig_fire)
	);

	// digital buffer of the trigger channel opens while the trigger is on
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			digital_input_enable <= '0;
		end else begin
			digital_input_enable <= '0;
			if (converter_control_two_q[adc_ctl_pkg::CTL2_TRIG_EN]
				&& !(adc_ctl_pkg::DEDICATED_TRIG_PRESENT && trig_sel_q[adc_ctl_pkg::TSEL_SOURCE])) begin
				digital_input_enable[an_sel] <= 1'b1; // RQ17
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			converter_control_two_q <= adc_ctl_pkg::CTL2_RST;
			trig_sel_q              <= adc_ctl_pkg::TSEL_RST;
			prescale_q              <= adc_ctl_pkg::PRESCALE_RST;
			thresh_q                <= adc_ctl_pkg::THRESH_RST;
			compare_enable_q        <= '0;
			irq_mask_q              <= '0;
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				adc_ctl_pkg::OFF_CTL2:     converter_control_two_q <= bus_req.wdata; // RQ2
				adc_ctl_pkg::OFF_TRIG_SEL: trig_sel_q <= bus_req.wdata;
				adc_ctl_pkg::OFF_PRESCALE: prescale_q <= bus_req.wdata[4:0];
				adc_ctl_pkg::OFF_THRESH:   thresh_q <= bus_req.wdata;
				adc_ctl_pkg::OFF_CMP_EN:   compare_enable_q <= bus_req.wdata[adc_ctl_pkg::SEQ_LEN-1:0];
				adc_ctl_pkg::OFF_IRQ_MASK: irq_mask_q <= bus_req.wdata[adc_ctl_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// conversion clock: prescaled bus clock, or fixed internal divider in stop with bit five set
	// the internal rate ignores the prescaler entirely
	assign div_limit = internal_clock_active ? {1'b0, adc_ctl_pkg::INT_CLK_DIV}
		: {prescale_q, 1'b1}; // RQ7
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_cnt_q <= 6'h00;
			tick_q    <= 1'b0;
		end else if (stop_enter || stop_exit || div_cnt_q >= div_limit) begin
			// restart on a clock switch so no short pulse leaks through
			div_cnt_q <= 6'h00;
			tick_q    <= ~(stop_enter | stop_exit);
		end else begin
			div_cnt_q <= div_cnt_q + 6'h01;
			tick_q    <= 1'b0;
		end
	end

	// clock source follows stop mode only when stop conversion is enabled
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			internal_clock_active <= 1'b0;
			stop_prev_q           <= 1'b0;
		end else begin
			stop_prev_q <= stop_s;
			if (stop_enter && stop_int_clk) begin
				internal_clock_active <= 1'b1; // RQ6
			end else if (stop_exit) begin
				internal_clock_active <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	assign conv_done = (state_q == adc_ctl_pkg::ST_CONVERT) && tick_q && !held_in_stop
		&& (tick_cnt_q == adc_ctl_pkg::CONV_TICKS - 4'h1) && !abort;
	// a conversion that crossed a mode change is thrown away
	assign store_ok = conv_done & ~tainted_q & ~stop_enter & ~stop_exit; // RQ9
	assign cmp_hit  = store_ok & compare_enable_q[idx_q] & (code_s2_q > thresh_q);
	assign seq_done = conv_done && (idx_q == adc_ctl_pkg::IDX_W'(adc_ctl_pkg::SEQ_LEN - 1));

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q    <= adc_ctl_pkg::ST_IDLE;
			idx_q      <= '0;
			tick_cnt_q <= 4'h0;
		end else if (abort) begin
			state_q    <= adc_ctl_pkg::ST_IDLE; // RQ1
			idx_q      <= '0;
			tick_cnt_q <= 4'h0;
		end else begin
			case (state_q)
				adc_ctl_pkg::ST_IDLE: begin
					if (start) begin
						state_q    <= adc_ctl_pkg::ST_CONVERT;
						idx_q      <= '0;
						tick_cnt_q <= 4'h0;
					end
				end
				adc_ctl_pkg::ST_CONVERT: begin
					// stop with internal clock keeps counting on its ticks
					if (tick_q && !held_in_stop) begin // RQ6
						if (conv_done) begin
							tick_cnt_q <= 4'h0;
							idx_q      <= idx_q + 1'b1;
							if (seq_done) begin
								state_q <= adc_ctl_pkg::ST_IDLE;
							end
						end else begin
							tick_cnt_q <= tick_cnt_q + 4'h1;
						end
					end
				end
				default: state_q <= adc_ctl_pkg::ST_IDLE;
			endcase
		end
	end

	// taint marks the conversion in flight across a run/stop change
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tainted_q <= 1'b0;
		end else if (start || conv_done || abort) begin
			tainted_q <= 1'b0;
		end else if ((stop_enter || stop_exit) && state_q == adc_ctl_pkg::ST_CONVERT) begin
			tainted_q <= 1'b1; // RQ9
		end
	end

	// a sequence killed by entering stop resumes from the start on exit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			restart_pending_q <= 1'b0;
		end else if (wr_ctl || stop_exit) begin
			restart_pending_q <= 1'b0;
		end else if (stop_enter && !stop_int_clk && state_q == adc_ctl_pkg::ST_CONVERT) begin
			restart_pending_q <= 1'b1; // RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// results and complete flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < adc_ctl_pkg::SEQ_LEN; i++) begin
				result_q[i] <= 8'h00;
			end
		end else if (store_ok) begin
			result_q[idx_q] <= code_s2_q; // RQ9
		end
	end

	// set wins over any clear arriving in the same cycle
	generate
		for (genvar n = 0; n < adc_ctl_pkg::SEQ_LEN; n++) begin : g_done_flag
			assign done_flag_set[n] = store_ok && (idx_q == n) && (!compare_enable_q[n] || cmp_hit);
			assign done_flag_clr[n] =
				(!fast_clear && bus_req.wr && bus_req.addr == adc_ctl_pkg::OFF_DONE_FLG
					&& bus_req.wdata[n]) // RQ3
				|| (fast_clear && !compare_enable_q[n] && bus_req.rd
					&& is_result(bus_req.addr) && acc_idx == n) // RQ4
				|| (fast_clear && compare_enable_q[n] && bus_req.wr
					&& is_result(bus_req.addr) && acc_idx == n); // RQ5
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			conversion_complete_flag_q <= '0;
		end else begin
			conversion_complete_flag_q <= (conversion_complete_flag_q & ~done_flag_clr) | done_flag_set;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, write one to clear, mask gates the line
	assign irq_set[adc_ctl_pkg::IRQ_SEQ_DONE] = seq_done;
	assign irq_set[adc_ctl_pkg::IRQ_CMP_HIT]  = cmp_hit;
	assign irq_set[adc_ctl_pkg::IRQ_ABORTED]  = abort & (state_q == adc_ctl_pkg::ST_CONVERT);

	// no stop gating here, so stop mode results still raise the line
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_stat_q <= '0;
			irq        <= 1'b0;
		end else begin
			if (bus_req.wr && bus_req.addr == adc_ctl_pkg::OFF_IRQ_STAT) begin
				irq_stat_q <= (irq_stat_q & ~bus_req.wdata[adc_ctl_pkg::IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_q <= irq_stat_q | irq_set; // RQ11
			end
			irq <= |(irq_stat_q & irq_mask_q); // RQ11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
			busy  <= 1'b0;
		end else begin
			busy  <= (state_q == adc_ctl_pkg::ST_CONVERT);
			rdata <= 8'h00;
			if (bus_req.rd) begin
				if (is_result(bus_req.addr)) begin
					rdata <= result_q[acc_idx];
				end else begin
					case (bus_req.addr)
						adc_ctl_pkg::OFF_CTL2:     rdata <= converter_control_two_q; // RQ2
						adc_ctl_pkg::OFF_TRIG_SEL: rdata <= trig_sel_q;
						adc_ctl_pkg::OFF_PRESCALE: rdata <= {3'h0, prescale_q};
						adc_ctl_pkg::OFF_THRESH:   rdata <= thresh_q;
						adc_ctl_pkg::OFF_DONE_FLG: rdata <= {4'h0, conversion_complete_flag_q};
						adc_ctl_pkg::OFF_CMP_EN:   rdata <= {4'h0, compare_enable_q};
						adc_ctl_pkg::OFF_IRQ_STAT: rdata <= {5'h00, irq_stat_q};
						adc_ctl_pkg::OFF_IRQ_MASK: rdata <= {5'h00, irq_mask_q};
						adc_ctl_pkg::OFF_STATUS:   rdata <= {2'h0, stop_s, restart_pending_q,
							internal_clock_active, (state_q == adc_ctl_pkg::ST_CONVERT), idx_q};
						default:                   rdata <= 8'h00;
					endcase
				end
			end
		end
	end

endmodule // adc_control

// ---- dv/adc_control_asserts.sv ----
// port checker of the converter control block
module adc_control_asserts (
	input  wire logic                           clk_sys,
	input  wire logic                           rstn,
	input  wire adc_ctl_pkg::reg_req_t          bus_req,
	input  wire logic [adc_ctl_pkg::DATA_W-1:0] rdata,
	input  wire adc_ctl_pkg::pins_t             pins,
	input  wire logic                           irq,
	input  wire logic [adc_ctl_pkg::CH_N-1:0]   digital_input_enable,
	input  wire logic                           internal_clock_active,
	input  wire logic                           busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] ctl2_q;
	logic [7:0] tsel_q;
	logic [7:0] den_exp;

	////////////////////////////////////////////////////////////////////////////
	// software copies: nothing inside the device writes these registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) ctl2_q <= adc_ctl_pkg::CTL2_RST;
		else if (bus_req.wr && bus_req.addr == adc_ctl_pkg::OFF_CTL2) ctl2_q <= bus_req.wdata;
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) tsel_q <= adc_ctl_pkg::TSEL_RST;
		else if (bus_req.wr && bus_req.addr == adc_ctl_pkg::OFF_TRIG_SEL) tsel_q <= bus_req.wdata;
	end
	// channel codes above seven fold onto the last channel; source bit plays no part
	always_comb den_exp = ctl2_q[2] ? (8'h01 << (tsel_q[3] ? 3'h7 : tsel_q[2:0])) : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read answer");
	ctl2_readback_a: assert property (bus_req.rd && bus_req.addr == adc_ctl_pkg::OFF_CTL2 |=> rdata == ctl2_q)
		else $error("control two read differs from last write");
	ctl2_write_abort_a: assert property (bus_req.wr && bus_req.addr == adc_ctl_pkg::OFF_CTL2 |-> ##[1:3] !busy)
		else $error("control two write left sequence running");
	irq_fall_cause_a: assert property ($fell(irq) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
		else $error("interrupt dropped without a software write");
	input_buffer_a: assert property (!bus_req.wr ##1 !bus_req.wr |=> digital_input_enable == den_exp)
		else $error("digital input buffer enable wrong");
	int_clk_cause_a: assert property (internal_clock_active |-> ctl2_q[5])
		else $error("internal clock active with stop clock bit clear");
	stop_abort_a: assert property ($rose(pins.stop_req) && !ctl2_q[5] && busy |-> ##[1:6] !busy)
		else $error("sequence not aborted on stop entry");
	stop_continue_a: assert property ($rose(pins.stop_req) && ctl2_q[5] && busy |-> ##[1:6] (internal_clock_active && busy))
		else $error("sequence did not continue on internal clock");
	stop_trig_block_a: assert property (internal_clock_active && !busy |=> !busy)
		else $error("sequence started while converting in stop mode");

	busy_rise_c: cover property ($rose(busy));
	irq_rise_c: cover property ($rose(irq));
	int_clk_rise_c: cover property ($rose(internal_clock_active));
endmodule // adc_control_asserts

bind adc_control adc_control_asserts u_adc_control_asserts (
	.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .pins(pins), .irq(irq),
	.digital_input_enable(digital_input_enable), .internal_clock_active(internal_clock_active), .busy(busy)
);

// ---- dv/adc_control_tb.sv ----
// self-checking testbench of the converter control block
module adc_control_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk_sys;
	logic                 rstn;
	adc_ctl_pkg::reg_req_t bus_req;
	adc_ctl_pkg::pins_t   pins;
	logic [7:0]           analog_code;
	logic [7:0]           rdata;
	logic                 irq;
	logic [7:0]           den;
	logic                 int_clk;
	logic                 busy;
	int                   fail_count;
	int                   check_count;

	adc_control DUT (
		.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .pins(pins),
		.analog_code(analog_code), .irq(irq), .digital_input_enable(den),
		.internal_clock_active(int_clk), .busy(busy)
	);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle strobes, changed right after the rising edge
	task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(negedge clk_sys);
		chk(rdata, e);
	endtask
	// bounded wait, sampled mid-cycle so edge updates have landed
	task automatic wait_busy(input logic v, input int lim);
		int n;
		n = 0;
		while (busy !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h0, busy}, {7'h0, v});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic run_seq();
		reg_wr(adc_ctl_pkg::OFF_START, 8'h01);
		wait_busy(1'b1, 4);
		wait_busy(1'b0, 200);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole run needs about a thousand cycles, a tenth of this limit
	initial begin
		#400000;
		fail_count++;
		complete_run();
	end

	initial begin
		fail_count = 0;
		check_count = 0;
		bus_req = '0;
		pins = '0;
		analog_code = 8'h40;
		rstn = 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		rd_chk(adc_ctl_pkg::OFF_CTL2, adc_ctl_pkg::CTL2_RST);
		rd_chk(adc_ctl_pkg::OFF_PRESCALE, {3'h0, adc_ctl_pkg::PRESCALE_RST});
		rd_chk(adc_ctl_pkg::OFF_THRESH, adc_ctl_pkg::THRESH_RST);
		rd_chk(5'h03, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h7b);
		rd_chk(adc_ctl_pkg::OFF_CTL2, 8'h7b);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_PRESCALE, 8'h00);
		$display("test reset_access done");
		// normal clearing and interrupt masking
		run_seq();
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		rd_chk(adc_ctl_pkg::OFF_RESULT, 8'h40);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		reg_wr(adc_ctl_pkg::OFF_DONE_FLG, 8'h01);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0e);
		rd_chk(adc_ctl_pkg::OFF_IRQ_STAT, 8'h01);
		chk({7'h0, irq}, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_IRQ_MASK, 8'h01);
		cyc(2);
		chk({7'h0, irq}, 8'h01);
		reg_wr(adc_ctl_pkg::OFF_IRQ_STAT, 8'h01);
		cyc(2);
		chk({7'h0, irq}, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		$display("test flags_irq done");
		// fast clear: read clears without compare, write clears with compare
		reg_wr(adc_ctl_pkg::OFF_THRESH, 8'h30);
		reg_wr(adc_ctl_pkg::OFF_CMP_EN, 8'h02);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h40);
		run_seq();
		rd_chk(adc_ctl_pkg::OFF_IRQ_STAT, 8'h03);
		rd_chk(adc_ctl_pkg::OFF_RESULT, 8'h40);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0e);
		rd_chk(adc_ctl_pkg::OFF_RESULT | 5'h01, 8'h40);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0e);
		reg_wr(adc_ctl_pkg::OFF_RESULT | 5'h01, 8'h00);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0c);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_CMP_EN, 8'h00);
		reg_wr(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		reg_wr(adc_ctl_pkg::OFF_IRQ_STAT, 8'h07);
		$display("test fast_clear done");
		// abort in mid-sequence
		reg_wr(adc_ctl_pkg::OFF_START, 8'h01);
		wait_busy(1'b1, 4);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h00);
		wait_busy(1'b0, 3);
		rd_chk(adc_ctl_pkg::OFF_IRQ_STAT, 8'h04);
		$display("test abort done");
		// stop with internal clock off: abort, then restart on exit
		reg_wr(adc_ctl_pkg::OFF_START, 8'h01);
		wait_busy(1'b1, 4);
		@(posedge clk_sys);
		pins.stop_req <= 1'b1;
		wait_busy(1'b0, 6);
		cyc(20);
		chk({7'h0, busy}, 8'h00);
		rd_chk(adc_ctl_pkg::OFF_STATUS, 8'h30);
		@(posedge clk_sys);
		pins.stop_req <= 1'b0;
		wait_busy(1'b1, 6);
		wait_busy(1'b0, 200);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		reg_wr(adc_ctl_pkg::OFF_DONE_FLG, 8'h0f);
		reg_wr(adc_ctl_pkg::OFF_IRQ_STAT, 8'h07);
		$display("test stop_abort done");
		// stop with internal clock on; slow prescaler must not slow it
		reg_wr(adc_ctl_pkg::OFF_PRESCALE, 8'h1f);
		reg_wr(adc_ctl_pkg::OFF_TRIG_SEL, 8'h02);
		reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h2c);
		reg_wr(adc_ctl_pkg::OFF_START, 8'h01);
		wait_busy(1'b1, 4);
		@(posedge clk_sys);
		pins.stop_req <= 1'b1;
		cyc(6);
		chk({7'h0, int_clk}, 8'h01);
		chk({7'h0, busy}, 8'h01);
		wait_busy(1'b0, 400);
		@(posedge clk_sys);
		pins.an_level[2] <= 1'b1;
		cyc(10);
		chk({7'h0, busy}, 8'h00);
		@(posedge clk_sys);
		pins.an_level[2] <= 1'b0;
		cyc(4);
		@(posedge clk_sys);
		pins.stop_req <= 1'b0;
		cyc(50);
		rd_chk(adc_ctl_pkg::OFF_DONE_FLG, 8'h0e);
		rd_chk(adc_ctl_pkg::OFF_IRQ_STAT, 8'h01);
		$display("test stop_continue done");
		// every trigger sensitivity, source bit set but ignored
		reg_wr(adc_ctl_pkg::OFF_TRIG_SEL, 8'h82);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys);
			pins.an_level[2] <= ~m[0];
			reg_wr(adc_ctl_pkg::OFF_CTL2, {3'h0, m[1:0], 3'h4});
			cyc(4);
			chk(den, 8'h04);
			chk({7'h0, busy}, 8'h00);
			@(posedge clk_sys);
			pins.an_level[2] <= m[0];
			wait_busy(1'b1, 10);
			reg_wr(adc_ctl_pkg::OFF_CTL2, 8'h00);
			wait_busy(1'b0, 3);
			cyc(3);
			chk(den, 8'h00);
		end
		$display("test trigger_modes done");
		complete_run();
	end
endmodule // adc_control_tb
